// ==== dv/test_i2c_master_event_shortcut_regs.sv ====
// Purpose: Register, event, shortcut and interrupt tests over APB.
// Assumes: Zero wait state slave; events come from the engine model.
// Notes:   Task pulses are counted by a monitor, index rx tx halt pause res.
`timescale 1ns/1ps
module test_i2c_master_event_shortcut_regs;
  logic        core_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slv;
  logic [9:0]  fire;
  logic [9:0]  evt;
  logic [4:0]  tsk;
  logic        irq;
  logic [3:0]  men;
  logic [31:0] q;
  logic [31:0] im;
  logic [31:0] b24;
  logic [31:0] sbit;
  int          cnt [5];
  int          tgt [6] = '{0, 3, 2, 1, 3, 2};
  int          s;
  int          mismatches;
  int          check_count;

  twm_engine_model u_eng (.clk(core_clk), .rst_b(rst_b), .fire(fire),
                          .evt(evt));
  twm_evt_regs DUT (.CORE_CLK(core_clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HALTED_EVT(evt[0]), .FAULT_EVT(evt[1]), .PAUSED_EVT(evt[2]),
    .RX_STARTED_EVT(evt[3]), .TX_STARTED_EVT(evt[4]),
    .FINAL_RX_EVT(evt[5]), .FINAL_TX_EVT(evt[6]), .OVERRUN_ERR(evt[7]),
    .ADDR_NACK_ERR(evt[8]), .DATA_NACK_ERR(evt[9]),
    .BEGIN_RX_TASK(tsk[0]), .BEGIN_TX_TASK(tsk[1]), .HALT_TASK(tsk[2]),
    .PAUSE_TASK(tsk[3]), .RESUME_TASK(tsk[4]), .IRQ(irq),
    .MASTER_ENABLE(men));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    for (int i = 0; i < 5; i++)
      if (tsk[i] === 1'b1)
        cnt[i]++;

  function automatic int total();
    return cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4];
  endfunction : total

  task automatic close_out();
    $display("Counts: checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    q       = prdata;
    slv     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task automatic pulse(input int i);
    @(posedge core_clk);
    fire <= 10'h001 << i;
    @(posedge core_clk);
    fire <= 10'h000;
    repeat (3) @(posedge core_clk);
  endtask : pulse

  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fire = 10'h000;
    im = 32'h0000_0000;
    b24 = 32'h1 << twm_evt_pkg::INT_POS[twm_evt_pkg::EV_TXFIN];
    for (int i = 0; i < 7; i++)
      im |= 32'h1 << twm_evt_pkg::INT_POS[i];
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(twm_evt_pkg::EVT_OFS[i], 32'h0);
    rd(twm_evt_pkg::OFS_SHORTCUT, 32'h0);
    rd(twm_evt_pkg::OFS_IRQ_EN, 32'h0);
    rd(twm_evt_pkg::OFS_ERRSRC, 32'h0);
    rd(twm_evt_pkg::OFS_ENABLE, 32'h0);
    $display("Test reset values done");
    apb(1'b1, twm_evt_pkg::OFS_IRQ_EN, b24);
    rd(twm_evt_pkg::OFS_IRQ_EN, b24);
    apb(1'b1, twm_evt_pkg::OFS_IRQ_SET, im);
    rd(twm_evt_pkg::OFS_IRQ_SET, im);
    apb(1'b1, twm_evt_pkg::OFS_IRQ_CLR, b24);
    rd(twm_evt_pkg::OFS_IRQ_CLR, im & ~b24);
    apb(1'b1, twm_evt_pkg::OFS_IRQ_SET, 32'h0);
    apb(1'b1, twm_evt_pkg::OFS_IRQ_CLR, 32'h0);
    rd(twm_evt_pkg::OFS_IRQ_EN, im & ~b24);
    apb(1'b1, twm_evt_pkg::OFS_IRQ_CLR, im);
    rd(twm_evt_pkg::OFS_IRQ_EN, 32'h0);
    $display("Test interrupt enable views done");
    for (int i = 0; i < 7; i++)
    begin
      pulse(i);
      rd(twm_evt_pkg::EVT_OFS[i], 32'h1);
      apb(1'b1, twm_evt_pkg::EVT_OFS[i], 32'h0);
      rd(twm_evt_pkg::EVT_OFS[i], 32'h0);
    end
    chk("tasks without shortcut", 32'h0, total());
    $display("Test event flags done");
    for (int k = 0; k < 6; k++)
    begin
      sbit = 32'h1 << (twm_evt_pkg::SC_LO + k);
      apb(1'b1, twm_evt_pkg::OFS_SHORTCUT, sbit);
      rd(twm_evt_pkg::OFS_SHORTCUT, sbit);
      s = cnt[tgt[k]];
      pulse(k < 3 ? twm_evt_pkg::EV_TXFIN : twm_evt_pkg::EV_RXFIN);
      chk("shortcut task", s + 1, cnt[tgt[k]]);
      chk("task total", k + 1, total());
    end
    apb(1'b1, twm_evt_pkg::OFS_TASK_RESUME, 32'h1);
    apb(1'b1, twm_evt_pkg::OFS_TASK_HALT, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("halt count", 32'h3, cnt[2]);
    chk("resume count", 32'h1, cnt[4]);
    apb(1'b1, twm_evt_pkg::OFS_SHORTCUT, 32'h0);
    apb(1'b1, twm_evt_pkg::EVT_OFS[5], 32'h0);
    apb(1'b1, twm_evt_pkg::EVT_OFS[6], 32'h0);
    $display("Test shortcuts done");
    apb(1'b1, twm_evt_pkg::OFS_IRQ_SET, b24);
    pulse(twm_evt_pkg::EV_TXFIN);
    chk("irq raised", 32'h1, irq);
    apb(1'b1, twm_evt_pkg::EVT_OFS[6], 32'h0);
    repeat (2) @(posedge core_clk);
    chk("irq after clear", 32'h0, irq);
    apb(1'b1, twm_evt_pkg::OFS_IRQ_CLR, b24);
    pulse(twm_evt_pkg::EV_TXFIN);
    chk("irq masked", 32'h0, irq);
    $display("Test interrupt done");
    for (int e = 0; e < 3; e++)
    begin
      pulse(7 + e);
      rd(twm_evt_pkg::OFS_ERRSRC, 32'h1 << e);
      apb(1'b1, twm_evt_pkg::OFS_ERRSRC, 32'h0);
      rd(twm_evt_pkg::OFS_ERRSRC, 32'h1 << e);
      apb(1'b1, twm_evt_pkg::OFS_ERRSRC, 32'h1 << e);
      rd(twm_evt_pkg::OFS_ERRSRC, 32'h0);
    end
    $display("Test error source done");
    apb(1'b0, 12'h400, 32'h0);
    chk("unmapped error", 32'h1, slv);
    chk("unmapped data", 32'h0, q);
    apb(1'b1, twm_evt_pkg::OFS_ENABLE, 32'h6);
    rd(twm_evt_pkg::OFS_ENABLE, 32'h6);
    chk("enable copy", 32'h6, men);
    chk("mapped error", 32'h0, slv);
    $display("Test bus map done");
    close_out();
  end
endmodule : test_i2c_master_event_shortcut_regs

// ==== dv/twm_engine_model.sv ====
// Purpose: Far-side protocol engine that turns bench requests into events.
// Assumes: Each request bit is copied to its event output one edge later.
// Notes:   Bits 0..6 follow the event index order, 7..9 the error bits.
`timescale 1ns/1ps
module twm_engine_model
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [9:0] fire,
  output logic      [9:0] evt
);
  // Outputs copy fire one edge later, so an event lasts as long as its request bit.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      evt <= '0;
    else
      evt <= fire;
endmodule : twm_engine_model

// ==== dv/twm_evt_regs_props.sv ====
// Purpose: Port-level checks of shortcuts and interrupt timing.
// Assumes: Shadow copies of the shortcut bits and of interrupt enable bit 24 follow APB writes.
// Notes:   Bound to every instance of the register block.
`timescale 1ns/1ps
module twm_evt_regs_props
(
  input wire logic        CORE_CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  input wire logic        FINAL_RX_EVT,
  input wire logic        FINAL_TX_EVT,
  input wire logic        BEGIN_RX_TASK,
  input wire logic        BEGIN_TX_TASK,
  input wire logic        HALT_TASK,
  input wire logic        PAUSE_TASK,
  input wire logic        IRQ
);
  logic [5:0] sc_ff;
  logic       en_ff;
  logic       wr;
  logic       rx_why;
  assign wr = PSEL & PENABLE & PWRITE;
  assign rx_why = (FINAL_TX_EVT && sc_ff[0]) ||
                  (wr && PADDR == twm_evt_pkg::OFS_TASK_RX && PWDATA[0]);
  always_ff @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B)
      sc_ff <= '0;
    else if (wr && PADDR == twm_evt_pkg::OFS_SHORTCUT)
      sc_ff <= PWDATA[12:7];
  always_ff @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B)
      en_ff <= 1'b0;
    else if (wr && PADDR == twm_evt_pkg::OFS_IRQ_EN)
      en_ff <= PWDATA[24];
    else if (wr && PADDR == twm_evt_pkg::OFS_IRQ_SET && PWDATA[24])
      en_ff <= 1'b1;
    else if (wr && PADDR == twm_evt_pkg::OFS_IRQ_CLR && PWDATA[24])
      en_ff <= 1'b0;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  property p_tx_rx; FINAL_TX_EVT && sc_ff[0] |=> BEGIN_RX_TASK; endproperty
  property p_tx_ps; FINAL_TX_EVT && sc_ff[1] |=> PAUSE_TASK; endproperty
  property p_tx_ht; FINAL_TX_EVT && sc_ff[2] |=> HALT_TASK; endproperty
  property p_rx_tx; FINAL_RX_EVT && sc_ff[3] |=> BEGIN_TX_TASK; endproperty
  property p_rx_ps; FINAL_RX_EVT && sc_ff[4] |=> PAUSE_TASK; endproperty
  property p_rx_ht; FINAL_RX_EVT && sc_ff[5] |=> HALT_TASK; endproperty
  property p_rx_cause; BEGIN_RX_TASK |-> $past(rx_why); endproperty
  property p_irq; FINAL_TX_EVT && en_ff |-> ##2 IRQ; endproperty
  a_tx_rx: assert property (p_tx_rx)
    else $error("receive task missing after tx final");
  a_tx_ps: assert property (p_tx_ps)
    else $error("pause task missing after tx final");
  a_tx_ht: assert property (p_tx_ht)
    else $error("halt task missing after tx final");
  a_rx_tx: assert property (p_rx_tx)
    else $error("transmit task missing after rx final");
  a_rx_ps: assert property (p_rx_ps)
    else $error("pause task missing after rx final");
  a_rx_ht: assert property (p_rx_ht)
    else $error("halt task missing after rx final");
  a_rx_cause: assert property (p_rx_cause)
    else $error("receive task without a cause");
  a_irq: assert property (p_irq)
    else $error("interrupt did not follow enabled event");
  c_sc: cover property (FINAL_RX_EVT && sc_ff[5]);
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (PSLVERR);
endmodule : twm_evt_regs_props
bind twm_evt_regs twm_evt_regs_props u_props (.CORE_CLK, .RST_B, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSLVERR, .FINAL_RX_EVT, .FINAL_TX_EVT,
  .BEGIN_RX_TASK, .BEGIN_TX_TASK, .HALT_TASK, .PAUSE_TASK, .IRQ);

// ==== logic/twm_evt_pkg.sv ====
// Purpose: Constants for the two-wire master event and shortcut registers.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Event index order is used by every per-event array.
package twm_evt_pkg;

  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NUM_EVT   = 7;
  localparam int unsigned EN_W      = 4;

  // Event indexes.
  localparam int unsigned EV_HALTED = 0;
  localparam int unsigned EV_FAULT  = 1;
  localparam int unsigned EV_PAUSED = 2;
  localparam int unsigned EV_RXBEG  = 3;
  localparam int unsigned EV_TXBEG  = 4;
  localparam int unsigned EV_RXFIN  = 5;
  localparam int unsigned EV_TXFIN  = 6;

  // Task trigger registers.
  localparam logic [11:0] OFS_TASK_RX     = 12'h000;
  localparam logic [11:0] OFS_TASK_TX     = 12'h008;
  localparam logic [11:0] OFS_TASK_HALT   = 12'h014;
  localparam logic [11:0] OFS_TASK_PAUSE  = 12'h01c;
  localparam logic [11:0] OFS_TASK_RESUME = 12'h020;

  // Event flag registers, in event index order.
  localparam logic [11:0] EVT_OFS [NUM_EVT] = '{
    12'h104, 12'h124, 12'h148, 12'h14c, 12'h150, 12'h15c, 12'h160};

  localparam logic [11:0] OFS_SHORTCUT = 12'h200;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET  = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h308;
  localparam logic [11:0] OFS_ERRSRC   = 12'h4c4;
  localparam logic [11:0] OFS_ENABLE   = 12'h500;

  // Interrupt enable bit position of each event, in event index order.
  localparam int unsigned INT_POS [NUM_EVT] = '{1, 9, 18, 19, 20, 23, 24};

  // Shortcut bit positions.
  localparam int unsigned SC_TX_RX    = 7;
  localparam int unsigned SC_TX_PAUSE = 8;
  localparam int unsigned SC_TX_HALT  = 9;
  localparam int unsigned SC_RX_TX    = 10;
  localparam int unsigned SC_RX_PAUSE = 11;
  localparam int unsigned SC_RX_HALT  = 12;
  localparam int unsigned SC_LO       = 7;
  localparam int unsigned SC_W        = 6;

  // Error source bit positions.
  localparam int unsigned ES_OVERRUN   = 0;
  localparam int unsigned ES_ADDR_NACK = 1;
  localparam int unsigned ES_DATA_NACK = 2;
  localparam int unsigned ES_W         = 3;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : twm_evt_pkg

// ==== logic/twm_evt_regs.sv ====
// Purpose: Event flags, shortcuts, interrupt enables and error source bits
//          of a two-wire bus master, reached by software over APB.
// Assumes: Event and error inputs are one-cycle pulses from the protocol
//          engine on CORE_CLK; tasks go back to it as one-cycle pulses.
// Notes:   Zero wait state slave; read data is sampled in the setup cycle.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps

// Functional notes
// - Paused flag goes to 1 once a pause has taken effect.
// - Final receive byte flag goes to 1 when the last receive byte begins.
// - Final transmit byte flag goes to 1 when last transmit byte begins.
// - Shortcut bit set: final transmit byte starts the receive task.
// - Shortcut bit set: final transmit byte triggers the pause task.
// - Shortcut bit set: final transmit byte triggers the halt task.
// - Shortcut bit set: final receive byte starts the transmit task.
// - Shortcut bit set: final receive byte triggers the pause task.
// - Shortcut bit set: final receive byte triggers halt; shortcuts reset 0.
// - Set view: writing 1 enables, 0 leaves alone; reads enable state.
// - Clear view: writing 1 disables, 0 leaves alone; reads enable state.
// - Overrun bit goes to 1 when a byte arrives before the last was stored.
// - Address not acknowledged bit sets on address NACK; write 1 clears.
// - Data not acknowledged bit sets on data NACK; write 1 clears.
// - Engine raises final receive byte after the proper acknowledge.
module twm_evt_regs
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST_B,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [11:0]              PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire logic                     HALTED_EVT,
  input  wire logic                     FAULT_EVT,
  input  wire logic                     PAUSED_EVT,
  input  wire logic                     RX_STARTED_EVT,
  input  wire logic                     TX_STARTED_EVT,
  input  wire logic                     FINAL_RX_EVT,
  input  wire logic                     FINAL_TX_EVT,
  input  wire logic                     OVERRUN_ERR,
  input  wire logic                     ADDR_NACK_ERR,
  input  wire logic                     DATA_NACK_ERR,
  output logic                          BEGIN_RX_TASK,
  output logic                          BEGIN_TX_TASK,
  output logic                          HALT_TASK,
  output logic                          PAUSE_TASK,
  output logic                          RESUME_TASK,
  output logic                          IRQ,
  output logic [twm_evt_pkg::EN_W-1:0]  MASTER_ENABLE
);

  localparam int unsigned NE = twm_evt_pkg::NUM_EVT;
  localparam int unsigned SC_HI = twm_evt_pkg::SC_LO + twm_evt_pkg::SC_W - 1;

  logic [NE-1:0]                    evt_in;
  logic [NE-1:0]                    flag_ff;
  logic [NE-1:0]                    irq_en_ff;
  logic [NE-1:0]                    nxt_irq_en;
  logic [SC_HI:twm_evt_pkg::SC_LO]  sc_ff;
  logic [twm_evt_pkg::ES_W-1:0]     errsrc_ff;
  logic [twm_evt_pkg::ES_W-1:0]     err_in;
  logic [twm_evt_pkg::EN_W-1:0]     enable_ff;
  logic [31:0]                      rdata_ff;
  logic [31:0]                      nxt_rdata;
  logic                             irq_ff;
  logic                             setup_rd;
  logic                             wr_acc;
  logic                             addr_hit;
  logic                             sw_rx;
  logic                             sw_tx;
  logic                             sw_halt;
  logic                             sw_pause;
  logic                             sw_resume;
  logic                             rx_task_ff;
  logic                             tx_task_ff;
  logic                             halt_task_ff;
  logic                             pause_task_ff;
  logic                             resume_task_ff;
  logic [31:0]                      irq_en_word;

  // Event inputs gathered in event index order.
  assign evt_in[twm_evt_pkg::EV_HALTED] = HALTED_EVT;
  assign evt_in[twm_evt_pkg::EV_FAULT]  = FAULT_EVT;
  assign evt_in[twm_evt_pkg::EV_PAUSED] = PAUSED_EVT;
  assign evt_in[twm_evt_pkg::EV_RXBEG]  = RX_STARTED_EVT;
  assign evt_in[twm_evt_pkg::EV_TXBEG]  = TX_STARTED_EVT;
  assign evt_in[twm_evt_pkg::EV_RXFIN]  = FINAL_RX_EVT;
  assign evt_in[twm_evt_pkg::EV_TXFIN]  = FINAL_TX_EVT;

  assign err_in[twm_evt_pkg::ES_OVERRUN] = OVERRUN_ERR;
  assign err_in[twm_evt_pkg::ES_ADDR_NACK] = ADDR_NACK_ERR;
  assign err_in[twm_evt_pkg::ES_DATA_NACK] = DATA_NACK_ERR;

  // APB decode; the slave never inserts wait states.
  assign PREADY   = 1'b1;
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign wr_acc   = PSEL && PENABLE && PWRITE;

  always_comb
  begin
    addr_hit = 1'b0;
    case (PADDR)
      twm_evt_pkg::OFS_TASK_RX,
      twm_evt_pkg::OFS_TASK_TX,
      twm_evt_pkg::OFS_TASK_HALT,
      twm_evt_pkg::OFS_TASK_PAUSE,
      twm_evt_pkg::OFS_TASK_RESUME,
      twm_evt_pkg::OFS_SHORTCUT,
      twm_evt_pkg::OFS_IRQ_EN,
      twm_evt_pkg::OFS_IRQ_SET,
      twm_evt_pkg::OFS_IRQ_CLR,
      twm_evt_pkg::OFS_ERRSRC,
      twm_evt_pkg::OFS_ENABLE:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
    for (int i = 0; i < NE; i++)
    begin
      if (PADDR == twm_evt_pkg::EVT_OFS[i])
      begin
        addr_hit = 1'b1;
      end
    end
  end

  assign PSLVERR = PSEL && PENABLE && !addr_hit;

  // Software task triggers: a write with bit 0 set fires the task.
  assign sw_rx     = wr_acc && PWDATA[0]
                     && (PADDR == twm_evt_pkg::OFS_TASK_RX);
  assign sw_tx     = wr_acc && PWDATA[0]
                     && (PADDR == twm_evt_pkg::OFS_TASK_TX);
  assign sw_halt   = wr_acc && PWDATA[0]
                     && (PADDR == twm_evt_pkg::OFS_TASK_HALT);
  assign sw_pause  = wr_acc && PWDATA[0]
                     && (PADDR == twm_evt_pkg::OFS_TASK_PAUSE);
  assign sw_resume = wr_acc && PWDATA[0]
                     && (PADDR == twm_evt_pkg::OFS_TASK_RESUME);

  // Event flags: an event in the cycle of a software write still sets it.
  for (genvar g = 0; g < NE; g++)
  begin : g_flag
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        flag_ff[g] <= 1'b0;
      end
      else if (evt_in[g])
      begin
        flag_ff[g] <= 1'b1;
      end
      else if (wr_acc && (PADDR == twm_evt_pkg::EVT_OFS[g]))
      begin
        flag_ff[g] <= PWDATA[0];
      end
    end
  end

  // Shortcut register.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sc_ff <= '0;
    end
    else if (wr_acc && (PADDR == twm_evt_pkg::OFS_SHORTCUT))
    begin
      sc_ff <= PWDATA[twm_evt_pkg::SC_LO +: twm_evt_pkg::SC_W];
    end
  end

  // Task pulses: software writes merged with event shortcuts.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_task_ff     <= 1'b0;
      tx_task_ff     <= 1'b0;
      halt_task_ff   <= 1'b0;
      pause_task_ff  <= 1'b0;
      resume_task_ff <= 1'b0;
    end
    else
    begin
      rx_task_ff     <= sw_rx
                        || (FINAL_TX_EVT
                            && sc_ff[twm_evt_pkg::SC_TX_RX]);
      tx_task_ff     <= sw_tx
                        || (FINAL_RX_EVT
                            && sc_ff[twm_evt_pkg::SC_RX_TX]);
      pause_task_ff  <= sw_pause
                        || (FINAL_TX_EVT
                            && sc_ff[twm_evt_pkg::SC_TX_PAUSE])
                        || (FINAL_RX_EVT
                            && sc_ff[twm_evt_pkg::SC_RX_PAUSE]);
      halt_task_ff   <= sw_halt
                        || (FINAL_TX_EVT
                            && sc_ff[twm_evt_pkg::SC_TX_HALT])
                        || (FINAL_RX_EVT
                            && sc_ff[twm_evt_pkg::SC_RX_HALT]);
      resume_task_ff <= sw_resume;
    end
  end

  assign BEGIN_RX_TASK = rx_task_ff;
  assign BEGIN_TX_TASK = tx_task_ff;
  assign HALT_TASK     = halt_task_ff;
  assign PAUSE_TASK    = pause_task_ff;
  assign RESUME_TASK   = resume_task_ff;

  // Interrupt enables through the plain, set and clear views.
  always_comb
  begin
    nxt_irq_en = irq_en_ff;
    for (int i = 0; i < NE; i++)
    begin
      if (wr_acc && (PADDR == twm_evt_pkg::OFS_IRQ_EN))
      begin
        nxt_irq_en[i] = PWDATA[twm_evt_pkg::INT_POS[i]];
      end
      else if (wr_acc && (PADDR == twm_evt_pkg::OFS_IRQ_SET)
               && PWDATA[twm_evt_pkg::INT_POS[i]])
      begin
        nxt_irq_en[i] = 1'b1;
      end
      else if (wr_acc && (PADDR == twm_evt_pkg::OFS_IRQ_CLR)
               && PWDATA[twm_evt_pkg::INT_POS[i]])
      begin
        nxt_irq_en[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      irq_en_ff <= '0;
    end
    else
    begin
      irq_en_ff <= nxt_irq_en;
    end
  end

  // Error source bits: write 1 clears, a new error in that cycle wins.
  for (genvar e = 0; e < twm_evt_pkg::ES_W; e++)
  begin : g_err
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        errsrc_ff[e] <= 1'b0;
      end
      else if (err_in[e])
      begin
        errsrc_ff[e] <= 1'b1;
      end
      else if (wr_acc && (PADDR == twm_evt_pkg::OFS_ERRSRC) && PWDATA[e])
      begin
        errsrc_ff[e] <= 1'b0;
      end
    end
  end

  // Master enable field is kept for the rest of the master.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      enable_ff <= '0;
    end
    else if (wr_acc && (PADDR == twm_evt_pkg::OFS_ENABLE))
    begin
      enable_ff <= PWDATA[twm_evt_pkg::EN_W-1:0];
    end
  end

  assign MASTER_ENABLE = enable_ff;

  // Interrupt request, registered.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= |(flag_ff & irq_en_ff);
    end
  end

  assign IRQ = irq_ff;

  // Read path: the word is captured in the setup cycle.
  always_comb
  begin
    irq_en_word = twm_evt_pkg::RST_WORD;
    for (int i = 0; i < NE; i++)
    begin
      irq_en_word[twm_evt_pkg::INT_POS[i]] = irq_en_ff[i];
    end
  end

  always_comb
  begin
    nxt_rdata = twm_evt_pkg::RST_WORD;
    case (PADDR)
      twm_evt_pkg::OFS_SHORTCUT:
      begin
        nxt_rdata[twm_evt_pkg::SC_LO +: twm_evt_pkg::SC_W] = sc_ff;
      end
      twm_evt_pkg::OFS_IRQ_EN,
      twm_evt_pkg::OFS_IRQ_SET,
      twm_evt_pkg::OFS_IRQ_CLR:
      begin
        nxt_rdata = irq_en_word;
      end
      twm_evt_pkg::OFS_ERRSRC:
      begin
        nxt_rdata[twm_evt_pkg::ES_W-1:0] = errsrc_ff;
      end
      twm_evt_pkg::OFS_ENABLE:
      begin
        nxt_rdata[twm_evt_pkg::EN_W-1:0] = enable_ff;
      end
      default:
      begin
        nxt_rdata = twm_evt_pkg::RST_WORD;
      end
    endcase
    for (int i = 0; i < NE; i++)
    begin
      if (PADDR == twm_evt_pkg::EVT_OFS[i])
      begin
        nxt_rdata[0] = flag_ff[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rdata_ff <= twm_evt_pkg::RST_WORD;
    end
    else if (setup_rd)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign PRDATA = rdata_ff;

endmodule : twm_evt_regs
